// [include/mbt_pkg.sv]
// Package for the multiplexer baud and tick timer bank
`default_nettype none
package mbt_pkg;
    // ----------------------------------------------------------------
    // Bank shape
    // ----------------------------------------------------------------
    localparam int MBT_UNITS = 3;
    localparam int MBT_CHANS = 4;
    localparam int MBT_CNT_W = 8;
    localparam int MBT_UNIT_W = 2;
    localparam int MBT_CHAN_W = 2;
    // Channel that only interrupts, and the unit allowed to interrupt
    localparam logic [MBT_CHAN_W-1:0] MBT_TICK_CHAN = 2'h3;
    localparam logic [MBT_UNIT_W-1:0] MBT_IRQ_UNIT = 2'h0;
    // ----------------------------------------------------------------
    // Reset value, and the count of one (decrement step and reload point)
    // ----------------------------------------------------------------
    localparam logic [MBT_CNT_W-1:0] MBT_CNT_RESET = 8'h00;
    localparam logic [MBT_CNT_W-1:0] MBT_CNT_ONE = 8'h01;
    // Source and core clock rates in units of 100 Hz (kHz times ten)
    localparam int MBT_SRC_KHZ_X10 = 18432;
    localparam int MBT_CORE_KHZ_X10 = 2500000;
    localparam int MBT_ACC_W = 24;
    // Host I/O port: address is unit in [3:2], channel in [1:0]
    typedef struct packed {
        logic [MBT_UNIT_W-1:0] unit;
        logic [MBT_CHAN_W-1:0] chan;
    } mbt_addr_t;
    typedef struct packed {
        logic wr;
        logic rd;
        mbt_addr_t addr;
        logic [MBT_CNT_W-1:0] wdata;
        logic irq_en;
    } mbt_io_req_t;
endpackage : mbt_pkg
`default_nettype wire

// [design/mbt_timers.sv]
// Three four-channel counter/timer units giving baud clocks, hold-off and tick
`timescale 1ns/10ps
`default_nettype none
// Function
// - Four independent channels per timer unit
// - Channels zero-two drive outputs; three interrupts only in unit zero, drives nothing elsewhere
// - Only unit zero may interrupt host
// - Units one and two never interrupt
// - Unit zero channel three is tick interrupt
// - All channels count common 1.8432 MHz source
// - Unit zero channel zero drives DMA hold-off
// - Unit zero channels 1,2 clock serial 1,0
// - Unit one channels clock serial channels 2-4
// - Unit two channels clock serial channels 5-7
// - Host reaches timers as I/O ports
module mbt_timers
    import mbt_pkg::*;
#(
    parameter int SRC_KHZ_X10 = MBT_SRC_KHZ_X10,
    parameter int CORE_KHZ_X10 = MBT_CORE_KHZ_X10
)(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire mbt_io_req_t io_req_in,
    output logic [MBT_CNT_W-1:0] io_rdata_out,
    output logic io_rvalid_out,
    output logic dma_request_holdoff_out,
    output logic [7:0] baud_clock_out,
    output logic tick_irq_out
);
    // ----------------------------------------------------------------
    // Common source clock enable
    // ----------------------------------------------------------------
    // Fractional accumulator makes the 1.8432 MHz rate on average; jitter
    // of one core cycle is traded for having a single clock domain.
    // Every channel of every unit counts this one strobe, so all baud
    // clocks share one reference. The strobe must not exceed half the
    // core rate, or the one-cycle output pulses would run together.
    localparam logic [MBT_ACC_W-1:0] ACC_STEP = MBT_ACC_W'(SRC_KHZ_X10);
    localparam logic [MBT_ACC_W-1:0] ACC_WRAP = MBT_ACC_W'(CORE_KHZ_X10);
    logic [MBT_ACC_W-1:0] acc; // Phase accumulator
    logic timer_source_clock; // One-cycle strobe per source clock
    wire [MBT_ACC_W:0] acc_sum = {1'b0, acc} + {1'b0, ACC_STEP};
    wire acc_hit = acc_sum >= {1'b0, ACC_WRAP};
    wire [MBT_ACC_W-1:0] next_acc = acc_hit ? MBT_ACC_W'(acc_sum - {1'b0, ACC_WRAP})
                                            : acc_sum[MBT_ACC_W-1:0];

    // Accumulator and strobe
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            acc <= '0;
            timer_source_clock <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            timer_source_clock <= acc_hit;
        end
    end

    // ----------------------------------------------------------------
    // Channel array
    // ----------------------------------------------------------------
    localparam int NCH = MBT_UNITS * MBT_CHANS;
    localparam int IDX_W = MBT_UNIT_W + MBT_CHAN_W;
    // Unpacked, so that each channel's process owns its own elements
    logic [MBT_CNT_W-1:0] count [NCH]; // Current down count
    logic [MBT_CNT_W-1:0] tconst [NCH]; // Time constant
    logic loaded [NCH]; // Constant written, channel runs
    logic zero_pulse [NCH]; // One-cycle pulse at zero count
    logic irq_enable; // Tick interrupt enable, unit zero only

    // Flat index of each routed channel (unit*4+chan)
    localparam int HOLDOFF_IDX = 0; // Unit 0 channel 0
    localparam int SER1_IDX = 1; // Unit 0 channel 1
    localparam int SER0_IDX = 2; // Unit 0 channel 2
    localparam int TICK_IDX = int'(MBT_IRQ_UNIT) * MBT_CHANS + int'(MBT_TICK_CHAN); // Unit 0 channel 3
    localparam int SER2_IDX = 4; // Unit 1 channel 0
    localparam int SER3_IDX = 5; // Unit 1 channel 1
    localparam int SER4_IDX = 6; // Unit 1 channel 2
    localparam int SER5_IDX = 8; // Unit 2 channel 0
    localparam int SER6_IDX = 9; // Unit 2 channel 1
    localparam int SER7_IDX = 10; // Unit 2 channel 2

    // Host write decode: flat index is unit*4+chan; unit 3 lies past the array
    wire [IDX_W-1:0] wr_index = {io_req_in.addr.unit, io_req_in.addr.chan};

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_chan
            localparam logic [IDX_W-1:0] IDX = IDX_W'(g);
            // A write hits at most one channel (none in unit 3) and restarts it at once
            wire wr_hit = io_req_in.wr && (wr_index == IDX);
            wire at_one = count[g] == MBT_CNT_ONE;
            // Zero of an 8-bit constant means 256, as with a full wrap
            wire [MBT_CNT_W-1:0] next_count = wr_hit ? io_req_in.wdata :
                (loaded[g] && timer_source_clock) ? (at_one ? tconst[g] : count[g] - MBT_CNT_ONE)
                : count[g];
            wire next_pulse = loaded[g] && timer_source_clock && at_one && !wr_hit;

            // Each channel keeps its own count and constant
            always_ff @(posedge core_clk_in)
            begin
                if (reset_in)
                begin
                    count[g] <= MBT_CNT_RESET;
                    tconst[g] <= MBT_CNT_RESET;
                    loaded[g] <= 1'b0;
                    zero_pulse[g] <= 1'b0;
                end
                else
                begin
                    if (wr_hit)
                    begin
                        tconst[g] <= io_req_in.wdata;
                        loaded[g] <= 1'b1;
                    end
                    count[g] <= next_count;
                    zero_pulse[g] <= next_pulse;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output routing
    // ----------------------------------------------------------------
    // Unit zero: ch0 hold-off, ch1 serial 1, ch2 serial 0, ch3 tick.
    // Units one and two: ch0..ch2 feed serial 2..7, ch3 feeds nothing.
    wire tick_event = zero_pulse[TICK_IDX] && irq_enable;
    wire holdoff_event = zero_pulse[HOLDOFF_IDX];
    // Serial channel n takes bit n; unit zero serves its two in swapped order
    wire [7:0] next_baud = {zero_pulse[SER7_IDX], zero_pulse[SER6_IDX], zero_pulse[SER5_IDX],
                            zero_pulse[SER4_IDX], zero_pulse[SER3_IDX], zero_pulse[SER2_IDX],
                            zero_pulse[SER1_IDX], zero_pulse[SER0_IDX]};

    // ----------------------------------------------------------------
    // Host port decode
    // ----------------------------------------------------------------
    // Addresses in unit 3 name no channel: they are neither read nor answered
    wire rd_unit_ok = io_req_in.addr.unit < MBT_UNIT_W'(MBT_UNITS);
    // Channel three of units one and two drives nothing; host polls it
    wire io_rd_hit = io_req_in.rd && rd_unit_ok;
    // Idle read data is zero, so a stale count never shows between reads
    wire [MBT_CNT_W-1:0] rd_count = io_rd_hit ? count[wr_index] : MBT_CNT_RESET;
    // Only a write to unit zero's tick channel carries the enable bit
    wire irq_unit_hit = io_req_in.addr.unit == MBT_IRQ_UNIT;
    wire irq_chan_hit = io_req_in.addr.chan == MBT_TICK_CHAN;
    wire irq_en_hit = io_req_in.wr && irq_unit_hit && irq_chan_hit;

    // Tick interrupt enable. Units one and two have no enable at all, so
    // no write from software can arm an interrupt outside unit zero.
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            irq_enable <= 1'b0;
        end
        else if (irq_en_hit)
        begin
            irq_enable <= io_req_in.irq_en;
        end
    end

    // Tick interrupt: one core cycle per zero count of unit zero channel three
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            tick_irq_out <= 1'b0;
        end
        else
        begin
            tick_irq_out <= tick_event;
        end
    end

    // DMA request hold-off pulse from unit zero channel zero
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            dma_request_holdoff_out <= 1'b0;
        end
        else
        begin
            dma_request_holdoff_out <= holdoff_event;
        end
    end

    // Baud clock pulses, one bit per serial channel
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            baud_clock_out <= 8'h00;
        end
        else
        begin
            baud_clock_out <= next_baud;
        end
    end

    // Read answer: valid and data stand for one cycle after the read strobe
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            io_rvalid_out <= 1'b0;
            io_rdata_out <= MBT_CNT_RESET;
        end
        else
        begin
            io_rvalid_out <= io_rd_hit;
            io_rdata_out <= rd_count;
        end
    end
endmodule : mbt_timers
`default_nettype wire

// [dv/mbt_timers_sva.sv]
// Checker for the baud and tick timer bank
`timescale 1ns/10ps
`default_nettype none
module mbt_timers_sva
    import mbt_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire mbt_io_req_t io_req_in,
    input wire logic [MBT_CNT_W-1:0] io_rdata_out,
    input wire logic io_rvalid_out,
    input wire logic dma_request_holdoff_out,
    input wire logic [7:0] baud_clock_out,
    input wire logic tick_irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // Unit 3 has no channels, so only live units must answer
    sequence s_rd;
        io_req_in.rd && io_req_in.addr.unit != 2'h3;
    endsequence
    a_read_answer: assert property (s_rd |=> io_rvalid_out)
        else $error("read not answered");
    a_answer_cause: assert property (io_rvalid_out |-> $past(io_req_in.rd))
        else $error("stray answer");
    a_rdata_idle: assert property (!io_rvalid_out |-> io_rdata_out == 8'h00)
        else $error("data not idle");
    a_write_silent: assert property (io_req_in.wr && !io_req_in.rd |=> !io_rvalid_out)
        else $error("write answered");
    a_tick_single: assert property (tick_irq_out |=> !tick_irq_out)
        else $error("tick too long");
    a_holdoff_once: assert property (dma_request_holdoff_out |=> !dma_request_holdoff_out)
        else $error("holdoff long");
    a_baud_single: assert property ((baud_clock_out & $past(baud_clock_out)) == 8'h00)
        else $error("baud long");
    a_reset_quiet: assert property ($fell(reset_in) |-> {tick_irq_out, baud_clock_out} == 9'h000)
        else $error("reset");
endmodule : mbt_timers_sva
bind mbt_timers mbt_timers_sva u_sva (.core_clk_in, .reset_in, .io_req_in, .io_rdata_out, .io_rvalid_out,
    .dma_request_holdoff_out, .baud_clock_out, .tick_irq_out);
`default_nettype wire

// [dv/mbt_host.sv]
// Host processor model issuing timer I/O port cycles
`timescale 1ns/10ps
`default_nettype none
module mbt_host
    import mbt_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic [MBT_CNT_W-1:0] io_rdata_in,
    input wire logic io_rvalid_in,
    output var mbt_io_req_t io_req_out
);
    initial io_req_out = '0;
    // One port cycle; idle data shows the inverse byte so stale data is never trusted
    task automatic io_cycle(input logic w, input logic [1:0] u, c, input logic [7:0] d, input logic e,
        output logic [7:0] q, output logic v);
        @(posedge core_clk_in);
        #1;
        io_req_out = '{wr: w, rd: !w, addr: '{unit: u, chan: c}, wdata: d, irq_en: e};
        @(posedge core_clk_in);
        #1;
        io_req_out = '{wr: 1'b0, rd: 1'b0, addr: '{unit: u, chan: c}, wdata: ~d, irq_en: 1'b0};
        q = io_rdata_in;
        v = io_rvalid_in;
    endtask : io_cycle
endmodule : mbt_host
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the baud and tick timer bank
`timescale 1ns/10ps
`default_nettype none
module tb import mbt_pkg::*;;
    logic core_clk_in;
    logic reset_in;
    logic rvalid, holdoff, tick, v;
    logic [7:0] rdata, baud, q;
    mbt_io_req_t req;
    int n_fail = 0;
    int checked = 0;
    // Observed bit of each routed channel, in unit*3+chan order
    localparam int MAP[9] = '{8, 1, 0, 2, 3, 4, 5, 6, 7};
    // Core cycles per source strobe here; a gap of NONE_CYC means no pulse came
    localparam int STROBE_CYC = 4;
    localparam int NONE_CYC = 1200;
    wire logic [9:0] obs = {tick, holdoff, baud};
    // Fast source strobe: one every 4 core cycles
    mbt_timers #(.SRC_KHZ_X10(10), .CORE_KHZ_X10(40)) u_mbt_timers (.core_clk_in, .reset_in, .io_req_in(req),
        .io_rdata_out(rdata), .io_rvalid_out(rvalid), .dma_request_holdoff_out(holdoff), .baud_clock_out(baud),
        .tick_irq_out(tick));
    mbt_host u_mbt_host (.core_clk_in, .io_rdata_in(rdata), .io_rvalid_in(rvalid), .io_req_out(req));
    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check
    // Cycles between two pulses of one output bit
    task automatic gap(input int b, output int t);
        repeat (2)
        begin
            t = 0;
            do
            begin
                @(posedge core_clk_in);
                #1;
                t++;
            end
            while (!obs[b] && t < NONE_CYC);
        end
    endtask : gap
    task automatic t_outputs;
        int t;
        for (int i = 0; i < 9; i++)
        begin
            u_mbt_host.io_cycle(1'b1, 2'(i / 3), 2'(i % 3), 8'(3 + i), 1'b0, q, v);
            gap(MAP[i], t);
            check(16'(t), 16'(STROBE_CYC * (3 + i)));
        end
    endtask : t_outputs
    task automatic t_ticks;
        int t;
        // Tick channel runs with its interrupt off; units one and two are asked to interrupt
        u_mbt_host.io_cycle(1'b1, 2'h0, 2'h3, 8'h02, 1'b0, q, v);
        u_mbt_host.io_cycle(1'b1, 2'h1, 2'h3, 8'h02, 1'b1, q, v);
        u_mbt_host.io_cycle(1'b1, 2'h2, 2'h3, 8'h02, 1'b1, q, v);
        gap(9, t);
        check(16'(t), 16'(NONE_CYC));
        u_mbt_host.io_cycle(1'b0, 2'h2, 2'h3, 8'h00, 1'b0, q, v);
        check({7'h00, v, 8'((q != 8'h00) && (q <= 8'h02))}, 16'h0101);
        // Unit 3 holds no channel: no answer, idle data
        u_mbt_host.io_cycle(1'b0, 2'h3, 2'h0, 8'h00, 1'b0, q, v);
        check({7'h00, v, q}, 16'h0000);
        u_mbt_host.io_cycle(1'b1, 2'h0, 2'h3, 8'h02, 1'b1, q, v);
        gap(9, t);
        check(16'(t), 16'(STROBE_CYC * 2));
        u_mbt_host.io_cycle(1'b1, 2'h0, 2'h3, 8'h02, 1'b0, q, v);
        gap(9, t);
        check(16'(t), 16'(NONE_CYC));
    endtask : t_ticks
    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial
    begin
        reset_in = 1'b1;
        repeat (10) @(posedge core_clk_in);
        #1;
        reset_in = 1'b0;
        t_outputs;
        t_ticks;
        tally_and_finish;
    end
    // Watchdog: the tests need about 5,400 cycles; 25,000 cycles means a hang
    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
